// ---- pkg/host_access_map.svh ----
`ifndef HOST_ACCESS_MAP_SVH
`define HOST_ACCESS_MAP_SVH

// Register word offsets on the host port
`define OFS_CHIP_IDENT 8'h50
`define OFS_IRQ_CFG 8'h54
`define OFS_INTERRUPT_STATUS_REG 8'h58
`define OFS_INT_EN 8'h5C
`define OFS_ENDIAN_TEST 8'h64
`define OFS_FIFO_INT 8'h68
`define OFS_RX_CFG 8'h6C
`define OFS_TX_CFG 8'h70
`define OFS_HW_CFG 8'h74
`define OFS_RX_DP_CTRL 8'h78
`define OFS_RX_FIFO_LEVEL 8'h7C
`define OFS_TX_FIFO_LEVEL 8'h80
`define OFS_PWR_MGMT 8'h84
`define OFS_GPIO_CFG 8'h88
`define OFS_GPT_CFG 8'h8C
`define OFS_GPT_COUNT 8'h90
`define OFS_WORD_SWAP 8'h98
`define OFS_FREE_RUN 8'h9C
`define OFS_RX_DROP 8'hA0
`define OFS_MAC_CSR_CMD 8'hA4
`define OFS_MAC_CSR_DATA 8'hA8
`define OFS_AFC_CFG 8'hAC
`define OFS_E2P_CMD 8'hB0
`define OFS_E2P_DATA 8'hB4
// FIFO ports (low window)
`define OFS_RX_DATA_FIFO 8'h00
`define OFS_RX_STS_FIFO 8'h40
`define OFS_TX_STS_FIFO 8'h48
`define OFS_TX_DATA_FIFO 8'h20

// Endian test pattern
`define ENDIAN_PATTERN 32'h87654321

// Wait times in ns
`define WAIT_NS_315 315
`define WAIT_NS_180 180
`define WAIT_NS_135 135
`define WAIT_NS_90 90
`define WAIT_NS_45 45
`define CLK_PERIOD_NS 10
// Cycle counts, least times rounded up
`define CYC_OF(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_315 `CYC_OF(`WAIT_NS_315)
`define CYC_180 `CYC_OF(`WAIT_NS_180)
`define CYC_135 `CYC_OF(`WAIT_NS_135)
`define CYC_90 `CYC_OF(`WAIT_NS_90)
`define CYC_45 `CYC_OF(`WAIT_NS_45)
// Device update latency, under the longest allowed
`define UPDATE_LAT 5'd12

`endif

// ---- pkg/host_access_pkg.sv ----
package host_access_pkg;
    typedef logic [7:0] addr_t;
    typedef logic [31:0] data_t;
    typedef logic [5:0] wait_t;
    typedef enum logic [1:0] {
        KIND_WRITE,
        KIND_FIFO_READ,
        KIND_DROP_READ,
        KIND_PLAIN_READ
    } access_kind_t;
endpackage : host_access_pkg

// ---- pkg/host_port_if.sv ----
`timescale 1ns/1ps
interface host_port_if;
    logic chip_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic fifo_sel;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic rdata_oe_n;

    modport device (
        input chip_select_n,
        input read_strobe_n,
        input write_strobe_n,
        input fifo_sel,
        input addr,
        input wdata,
        output rdata,
        output rdata_oe_n
    );
    modport host (
        output chip_select_n,
        output read_strobe_n,
        output write_strobe_n,
        output fifo_sel,
        output addr,
        output wdata,
        input rdata,
        input rdata_oe_n
    );
endinterface : host_port_if

// ---- hw/spacing_timer.sv ----
`timescale 1ns/1ps
`include "host_access_map.svh"
module spacing_timer
    import host_access_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic [7:0] kind_mask,
    output logic [5:0] elapsed
);
    // Saturating count of cycles since last restart
    logic [5:0] elapsed_nxt;
    logic [7:0] unused_mask;
    assign unused_mask = kind_mask;

    always_comb begin
        elapsed_nxt = elapsed;
        if (restart) begin
            elapsed_nxt = 6'h00;
        end else if (elapsed != 6'h3F) begin
            elapsed_nxt = elapsed + 6'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            elapsed <= 6'h3F;
        end else begin
            elapsed <= elapsed_nxt;
        end
    end
endmodule : spacing_timer

// ---- hw/host_access_device.sv ----
`timescale 1ns/1ps
`include "host_access_map.svh"
module host_access_device
    import host_access_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    host_port_if.device port,
    input wire logic [31:0] rx_fifo_word,
    input wire logic [31:0] chip_ident,
    output logic tx_push,
    output logic [31:0] tx_push_data,
    output logic rx_pop
);
    import host_access_pkg::*;
    // Simple model of level registers delayed after side effects
    logic active_r, active_nxt;
    logic wr_active_r, wr_active_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic oe_n_r, oe_n_nxt;
    logic tx_push_r, tx_push_nxt, rx_pop_r, rx_pop_nxt;
    logic [31:0] tx_data_r, tx_data_nxt;
    logic [7:0] tx_level_r, tx_level_nxt, tx_live_r, tx_live_nxt;
    logic [7:0] rx_drop_r, rx_drop_nxt;
    logic [4:0] lat_r, lat_nxt;
    logic rd_on, wr_on;

    assign rd_on = !port.chip_select_n && !port.read_strobe_n;
    assign wr_on = !port.chip_select_n && !port.write_strobe_n;

    always_comb begin
        active_nxt = rd_on;
        wr_active_nxt = wr_on;
        rdata_nxt = rdata_r;
        oe_n_nxt = !rd_on;
        tx_push_nxt = 1'b0;
        rx_pop_nxt = 1'b0;
        tx_data_nxt = tx_data_r;
        tx_live_nxt = tx_live_r;
        tx_level_nxt = tx_level_r;
        rx_drop_nxt = rx_drop_r;
        lat_nxt = (lat_r != 5'd0) ? lat_r - 5'd1 : 5'd0;
        if (lat_r == 5'd1) begin
            tx_level_nxt = tx_live_r;
        end
        // three read kinds at start edge: fifo, drop, plain
        if (rd_on && !active_r) begin
            if (port.fifo_sel || port.addr == `OFS_RX_DATA_FIFO) begin
                rdata_nxt = rx_fifo_word;
                rx_pop_nxt = 1'b1;
            end else begin
                unique case (port.addr)
                    `OFS_CHIP_IDENT: rdata_nxt = chip_ident;
                    `OFS_ENDIAN_TEST: rdata_nxt = `ENDIAN_PATTERN;
                    `OFS_TX_FIFO_LEVEL: rdata_nxt = {24'h000000, tx_level_r};
                    `OFS_RX_DROP: begin
                        rdata_nxt = {24'h000000, rx_drop_r};
                        rx_drop_nxt = 8'h00;
                    end
                    default: rdata_nxt = 32'h00000000;
                endcase
            end
        end else if (rd_on && port.fifo_sel && port.addr != addr_t'(0)) begin
            // Burst: nonzero address reloads rx_fifo_word each cycle, without rx_pop
            rdata_nxt = rx_fifo_word;
        end
        if (wr_on && !wr_active_r) begin
            if (port.addr == `OFS_TX_DATA_FIFO) begin
                tx_push_nxt = 1'b1;
                tx_data_nxt = port.wdata;
                tx_live_nxt = tx_live_r + 8'h01;
                lat_nxt = `UPDATE_LAT;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_r <= 1'b0;
            wr_active_r <= 1'b0;
            rdata_r <= 32'h00000000;
            oe_n_r <= 1'b1;
            tx_push_r <= 1'b0;
            rx_pop_r <= 1'b0;
            tx_data_r <= 32'h00000000;
            tx_live_r <= 8'h00;
            tx_level_r <= 8'h00;
            rx_drop_r <= 8'h00;
            lat_r <= 5'd0;
        end else begin
            active_r <= active_nxt;
            wr_active_r <= wr_active_nxt;
            rdata_r <= rdata_nxt;
            oe_n_r <= oe_n_nxt;
            tx_push_r <= tx_push_nxt;
            rx_pop_r <= rx_pop_nxt;
            tx_data_r <= tx_data_nxt;
            tx_live_r <= tx_live_nxt;
            tx_level_r <= tx_level_nxt;
            rx_drop_r <= rx_drop_nxt;
            lat_r <= lat_nxt;
        end
    end

    assign port.rdata = rdata_r;
    assign port.rdata_oe_n = oe_n_r;
    assign tx_push = tx_push_r;
    assign tx_push_data = tx_data_r;
    assign rx_pop = rx_pop_r;
endmodule : host_access_device

// ---- hw/host_access_host.sv ----
`timescale 1ns/1ps
`include "host_access_map.svh"
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - device takes three read cycle kinds
// - device acts on tx fifo writes only, register writes ignored
// - tx level lags fifo write 12 cycles, 120ns
// - host waits per register after writes
// - 135ns before irq, tx level, timer
// - 315ns power mgmt, 180ns free counter
// - 90ns int status, 45ns others
// - no wait for ident, endian, rx
// - endian test reads may fill wait
// - slower bus needs fewer dummy reads
// - any method meeting wait suffices
// - side-effect reads update status late
// - tx status read, 135ns before tx level
// - rx drop read, 180ns before again
// - cycle spans chip select and one strobe asserted
module host_access_host
    import host_access_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    host_port_if.host port,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [7:0] req_addr,
    input wire logic [31:0] req_wdata,
    output logic req_ready,
    output logic resp_valid,
    output logic [31:0] resp_data
);
    import host_access_pkg::*;
    typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_ACCESS, ST_GAP} state_t;
    localparam logic [1:0] ACC_CYC = 2'd3;
    localparam logic [1:0] GAP_CYC = 2'd1;

    state_t state_r, state_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic write_r, write_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic cs_n_r, cs_n_nxt, rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt;
    logic ready_r, ready_nxt, rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [7:0] last_rd_r, last_rd_nxt;
    logic restart;
    logic [5:0] since_wr, since_rd;
    logic [5:0] need;

    spacing_timer u_wr_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .restart(restart && write_r),
        .kind_mask(8'h00),
        .elapsed(since_wr)
    );
    spacing_timer u_rd_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .restart(restart && !write_r),
        .kind_mask(8'h00),
        .elapsed(since_rd)
    );

    // Required gap before read of addr_r
    always_comb begin
        need = 6'd0;
        if (!write_r) begin
            unique case (addr_r)
                `OFS_CHIP_IDENT, `OFS_ENDIAN_TEST, `OFS_RX_FIFO_LEVEL,
                `OFS_RX_DROP, `OFS_RX_DATA_FIFO, `OFS_RX_STS_FIFO,
                `OFS_TX_STS_FIFO: need = 6'd0;
                `OFS_IRQ_CFG, `OFS_TX_FIFO_LEVEL, `OFS_GPT_COUNT:
                    need = 6'(`CYC_135);
                `OFS_PWR_MGMT: need = 6'(`CYC_315);
                `OFS_FREE_RUN: need = 6'(`CYC_180);
                `OFS_INTERRUPT_STATUS_REG: need = 6'(`CYC_90);
                default: need = 6'(`CYC_45);
            endcase
            if (since_wr >= need) begin
                need = 6'd0;
            end
            // rx fifo reads before rx level
            if (addr_r == `OFS_RX_FIFO_LEVEL &&
                (last_rd_r == `OFS_RX_DATA_FIFO ||
                 last_rd_r == `OFS_RX_STS_FIFO) &&
                since_rd < 6'(`CYC_135)) begin
                need = 6'h3F;
            end
            if (addr_r == `OFS_TX_FIFO_LEVEL &&
                last_rd_r == `OFS_TX_STS_FIFO &&
                since_rd < 6'(`CYC_135)) begin
                need = 6'h3F;
            end
            if (addr_r == `OFS_RX_DROP && last_rd_r == `OFS_RX_DROP &&
                since_rd < 6'(`CYC_180)) begin
                need = 6'h3F;
            end
        end
    end

    assign restart = (state_r == ST_ACCESS) && (cnt_r == 2'd0);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        write_nxt = write_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        cs_n_nxt = cs_n_r;
        rd_n_nxt = rd_n_r;
        wr_n_nxt = wr_n_r;
        ready_nxt = ready_r;
        rvalid_nxt = 1'b0;
        rdata_nxt = rdata_r;
        last_rd_nxt = last_rd_r;
        unique case (state_r)
            ST_IDLE: begin
                if (req_valid && ready_r) begin
                    write_nxt = req_write;
                    addr_nxt = req_addr;
                    wdata_nxt = req_wdata;
                    ready_nxt = 1'b0;
                    state_nxt = ST_HOLD;
                end
            end
            // waiting by time, no dummy reads
            // time gap stands for dummy reads
            ST_HOLD: begin
                if (need == 6'd0 || write_r) begin
                    cs_n_nxt = 1'b0;
                    rd_n_nxt = write_r;
                    wr_n_nxt = !write_r;
                    cnt_nxt = ACC_CYC;
                    state_nxt = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (cnt_r != 2'd0) begin
                    cnt_nxt = cnt_r - 2'd1;
                end else begin
                    cs_n_nxt = 1'b1;
                    rd_n_nxt = 1'b1;
                    wr_n_nxt = 1'b1;
                    if (!write_r) begin
                        rdata_nxt = port.rdata;
                        rvalid_nxt = 1'b1;
                        last_rd_nxt = addr_r;
                    end
                    cnt_nxt = GAP_CYC;
                    state_nxt = ST_GAP;
                end
            end
            ST_GAP: begin
                // Deassertion time between cycles
                if (cnt_r != 2'd0) begin
                    cnt_nxt = cnt_r - 2'd1;
                end else begin
                    ready_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cnt_r <= 2'd0;
            write_r <= 1'b0;
            addr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            cs_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            ready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            last_rd_r <= `OFS_ENDIAN_TEST;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            write_r <= write_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            cs_n_r <= cs_n_nxt;
            rd_n_r <= rd_n_nxt;
            wr_n_r <= wr_n_nxt;
            ready_r <= ready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            last_rd_r <= last_rd_nxt;
        end
    end

    assign port.chip_select_n = cs_n_r;
    assign port.read_strobe_n = rd_n_r;
    assign port.write_strobe_n = wr_n_r;
    assign port.fifo_sel = 1'b0;
    assign port.addr = addr_r;
    assign port.wdata = wdata_r;
    assign req_ready = ready_r;
    assign resp_valid = rvalid_r;
    assign resp_data = rdata_r;
endmodule : host_access_host

// ---- verification/host_access_assertions.sv ----
`timescale 1ns/1ps
`include "host_access_map.svh"
module host_access_assertions (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic fifo_sel,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic rdata_oe_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic rd_on;
    logic reg_rd;
    logic [3:0] hit;
    logic [5:0] cnt_r [4];
    logic [5:0] cnt_nxt [4];
    assign rd_on = !chip_select_n && !read_strobe_n;
    assign reg_rd = rd_on && !fifo_sel;
    assign hit[0] = !chip_select_n && !write_strobe_n;
    assign hit[1] = rd_on && (fifo_sel || addr == `OFS_RX_DATA_FIFO
        || addr == `OFS_RX_STS_FIFO);
    assign hit[2] = reg_rd && addr == `OFS_TX_STS_FIFO;
    assign hit[3] = reg_rd && addr == `OFS_RX_DROP;
    // Saturate, so a long idle never wraps into a short gap
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cnt_nxt[i] = hit[i] ? 6'h00
                : cnt_r[i] + {5'h00, cnt_r[i] != 6'h3F};
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                cnt_r[i] <= 6'h3F;
            end
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
////////////////////////////////////////////////////////////////////////////
    sequence s_rd_go;
        !rd_on ##1 rd_on;
    endsequence
    property p_gap(logic ok, logic [5:0] c, int n);
        s_rd_go ##0 (!fifo_sel && ok) |-> c >= n;
    endproperty
    a_wr_135_gap: assert property (p_gap(addr inside {`OFS_IRQ_CFG,
        `OFS_TX_FIFO_LEVEL, `OFS_GPT_COUNT}, cnt_r[0], `CYC_135))
        else $error("read too soon after write");
    a_pwr_mgmt_gap: assert property (
        p_gap(addr == `OFS_PWR_MGMT, cnt_r[0], `CYC_315))
        else $error("power control read too soon");
    a_free_run_gap: assert property (
        p_gap(addr == `OFS_FREE_RUN, cnt_r[0], `CYC_180))
        else $error("free counter read too soon");
    a_interrupt_status_reg_gap: assert property (
        p_gap(addr == `OFS_INTERRUPT_STATUS_REG, cnt_r[0], `CYC_90))
        else $error("interrupt status read too soon");
    a_cfg_reg_gap: assert property (p_gap(addr >= 8'h54 && !(addr
        inside {`OFS_ENDIAN_TEST, `OFS_RX_FIFO_LEVEL, `OFS_RX_DROP}),
        cnt_r[0], `CYC_45)) else $error("register read too soon");
    a_rx_level_gap: assert property (
        p_gap(addr == `OFS_RX_FIFO_LEVEL, cnt_r[1], `CYC_135))
        else $error("rx level read too soon");
    a_tx_level_gap: assert property (
        p_gap(addr == `OFS_TX_FIFO_LEVEL, cnt_r[2], `CYC_135))
        else $error("tx level read too soon");
    a_drop_again_gap: assert property (
        p_gap(addr == `OFS_RX_DROP, cnt_r[3], `CYC_180))
        else $error("drop counter reread too soon");
    a_read_answer: assert property (s_rd_go |=> !rdata_oe_n)
        else $error("read not answered");
    a_endian_data: assert property (s_rd_go ##0
        (!fifo_sel && addr == `OFS_ENDIAN_TEST) |=> rdata == `ENDIAN_PATTERN)
        else $error("endian pattern wrong");
    a_oe_release: assert property (!rd_on |=> rdata_oe_n)
        else $error("data driven outside read");
endmodule : host_access_assertions

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`include "host_access_map.svh"
module tb;
    import host_access_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    addr_t req_addr = 8'h00;
    data_t req_wdata = 32'h0;
    data_t rx_fifo_word = 32'h0;
    data_t chip_ident = 32'h0;
    logic req_ready, resp_valid, tx_push, rx_pop;
    data_t resp_data, tx_push_data, q;
    data_t exp_q[$];
    data_t got_q[$];
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int take_cyc = 0;
    int pops = 0;
    int p;
    int seed = 32'h8017;
    addr_t regs[24] = '{8'h50, 8'h54, 8'h58, 8'h5C, 8'h64, 8'h68, 8'h6C,
        8'h70, 8'h74, 8'h78, 8'h7C, 8'h80, 8'h84, 8'h88, 8'h8C, 8'h90,
        8'h98, 8'h9C, 8'hA0, 8'hA4, 8'hA8, 8'hAC, 8'hB0, 8'hB4};

    always #5 core_clk = ~core_clk;

    host_port_if port_if ();
    host_access_host host_access_host_inst (.core_clk, .rst_n,
        .port(port_if), .req_valid, .req_write, .req_addr, .req_wdata,
        .req_ready, .resp_valid, .resp_data);
    host_access_device host_access_device_inst (.core_clk, .rst_n,
        .port(port_if), .rx_fifo_word, .chip_ident, .tx_push,
        .tx_push_data, .rx_pop);
    host_access_assertions chk_inst (.core_clk, .rst_n,
        .chip_select_n(port_if.chip_select_n),
        .read_strobe_n(port_if.read_strobe_n),
        .write_strobe_n(port_if.write_strobe_n),
        .fifo_sel(port_if.fifo_sel), .addr(port_if.addr),
        .wdata(port_if.wdata), .rdata(port_if.rdata),
        .rdata_oe_n(port_if.rdata_oe_n));

    // Run is about a thousand cycles; far above that means a hang
    always @(posedge core_clk) begin
        cyc++;
        if (tx_push === 1'b1) got_q.push_back(tx_push_data);
        if (rx_pop === 1'b1) pops++;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
////////////////////////////////////////////////////////////////////////////
    task automatic check(input data_t seen, input data_t exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    function automatic int wait_ns(input addr_t a);
        case (a)
            `OFS_PWR_MGMT: return 315;
            `OFS_FREE_RUN: return 180;
            `OFS_IRQ_CFG, `OFS_TX_FIFO_LEVEL, `OFS_GPT_COUNT: return 135;
            `OFS_INTERRUPT_STATUS_REG: return 90;
            `OFS_CHIP_IDENT, `OFS_ENDIAN_TEST: return 0;
            `OFS_RX_FIFO_LEVEL, `OFS_RX_DROP: return 0;
            default: return 45;
        endcase
    endfunction : wait_ns

    // Entered and left at a falling edge
    task automatic do_req(input logic wr, input addr_t a, input data_t d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        @(negedge core_clk);
        take_cyc = cyc;
        req_valid = 1'b0;
        while ((wr ? req_ready : resp_valid) !== 1'b1 && n < 600) begin
            @(negedge core_clk);
            n++;
        end
        check(data_t'(n < 600), 32'h1);
        q = resp_data;
        if (!wr && a == `OFS_ENDIAN_TEST) check(q, `ENDIAN_PATTERN);
        if (!wr && a == `OFS_CHIP_IDENT) check(q, chip_ident);
        // Level counts every fifo write so far, none drained here
        if (!wr && a == `OFS_TX_FIFO_LEVEL)
            check(q, data_t'(exp_q.size()));
        if (wr && a == `OFS_TX_DATA_FIFO) exp_q.push_back(d);
    endtask : do_req

    // Two requests; the second answer may not come before the wait
    task automatic pair(input logic wr, input addr_t a, input addr_t b,
        input int ns);
        int t;
        rx_fifo_word = $random(seed);
        do_req(wr, a, rx_fifo_word);
        t = take_cyc;
        do_req(1'b0, b, 32'h0);
        check(data_t'(cyc - t >= (ns + 9) / 10 + 6), 32'h1);
    endtask : pair

    initial begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        chip_ident = $random(seed);
        foreach (regs[i]) pair(1'b1, `OFS_TX_DATA_FIFO, regs[i],
            wait_ns(regs[i]));
        $display("test write_then_read done");
        pair(1'b0, `OFS_RX_DATA_FIFO, `OFS_RX_FIFO_LEVEL, 135);
        pair(1'b0, `OFS_RX_STS_FIFO, `OFS_RX_FIFO_LEVEL, 135);
        pair(1'b0, `OFS_TX_STS_FIFO, `OFS_TX_FIFO_LEVEL, 135);
        pair(1'b0, `OFS_RX_DROP, `OFS_RX_DROP, 180);
        check(q, 32'h0);
        p = pops;
        do_req(1'b0, `OFS_RX_DATA_FIFO, 32'h0);
        check(q, rx_fifo_word);
        check(data_t'(pops - p), 32'h1);
        $display("test read_then_read done");
        repeat (40) begin
            rx_fifo_word = $random(seed);
            p = {$random(seed)} % 24;
            if (rx_fifo_word[0]) begin
                do_req(1'b1, `OFS_TX_DATA_FIFO, $random(seed));
            end else begin
                do_req(1'b0, regs[p], 32'h0);
            end
        end
        check(data_t'(got_q.size()), data_t'(exp_q.size()));
        foreach (exp_q[i]) check(got_q[i], exp_q[i]);
        $display("test random_mix done");
        give_verdict();
    end
endmodule : tb
